// ===== inc/ckl_defines.svh
// constants for the console keypad command logic
// assumes a 10 MHz system clock; included by bare name
`ifndef CKL_DEFINES_SVH
`define CKL_DEFINES_SVH

`define CKL_CLK_KHZ   10000
`define CKL_INIT_MS   150
`define CKL_DEB_MS    5
`define CKL_TMO_US    20
`define CKL_TMO_CYC   ((`CKL_TMO_US * `CKL_CLK_KHZ + 999) / 1000)

`define CKL_PC_ADDR   18'h3ffc7
`define CKL_GPR_LO    18'h3ffc8
`define CKL_GPR_HI    18'h3ffcf
`define CKL_STEP_WIDE 18'h00002
`define CKL_STEP_GPR  18'h00001
`define CKL_ZERO      18'h00000
`define CKL_HI_ZERO   2'h0

`define CKL_NKEYS     20
`define CKL_K_LSR     8
`define CKL_K_LAD     9
`define CKL_K_DEP     10
`define CKL_K_EXAMINE_KEY    11
`define CKL_K_CLR     12
`define CKL_K_DISAD   13
`define CKL_K_HS      14
`define CKL_K_CONT    15
`define CKL_K_START   16
`define CKL_K_INIT    17
`define CKL_K_BOOT    18
`define CKL_K_MOD     19
`define CKL_D_ADD7    7
`define CKL_D_ADD6    6
`define CKL_D_MAINT   1

`endif

// ===== inc/ckl_pkg.sv
// types shared by the console keypad command logic
// no assumptions beyond a SystemVerilog compiler
package ckl_pkg;
  typedef logic [17:0] ckl_addr_t;
  typedef logic [15:0] ckl_word_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_HALT = 3'b001,
    S_STEP = 3'b010,
    S_BUS  = 3'b011,
    S_INIT = 3'b100
  } ckl_state_e;
  typedef enum logic [1:0] {
    OP_PC    = 2'b00,
    OP_EXAMINE_KEY  = 2'b01,
    OP_DEP   = 2'b10,
    OP_START = 2'b11
  } ckl_op_e;
endpackage

// ===== hdl/ckl_keydeb.sv
// key debouncer: three-stage synchroniser, stability filter, press edge
// assumes raw keys are asynchronous pins, active high while pressed
`timescale 1ns/1ps
module ckl_keydeb #(
  parameter int W      = 20,
  parameter int STABLE = 50000
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] held,
  output logic      [W-1:0] press
);
  localparam int CW = $clog2(STABLE + 1);

  if (W < 1 || STABLE < 2) begin : g_bad
    $error("ckl_keydeb: W and STABLE out of range");
  end

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] held_q_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      held_q_reg <= '0;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      held_q_reg <= held;
    end
  end

  // a held key yields exactly one press pulse
  assign press = held & ~held_q_reg; // R22

  for (genvar i = 0; i < W; i++) begin : g_key
    logic [CW-1:0] cnt_reg;
    logic          lvl_reg;
    always_ff @(posedge clk) begin
      if (rst) begin
        cnt_reg <= '0;
        lvl_reg <= 1'b0;
      end else if (s2_reg[i] != s3_reg[i] || s3_reg[i] == lvl_reg) begin
        cnt_reg <= '0;
      end else if (cnt_reg == CW'(STABLE - 1)) begin
        lvl_reg <= s3_reg[i]; // R22
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + CW'(1);
      end
    end
    assign held[i] = lvl_reg;

    a_press_once: assert property (@(posedge clk) disable iff (rst) // R22
      press[i] |=> !press[i])
      else $error("press pulse longer than one cycle");
  end
endmodule

// ===== hdl/ckl_console.sv
// console keypad command logic: keys, octal display, halt control, bus
// assumes processor handshakes and bus answers are synchronous to clk
//
// Contract
// R1: modifier must already be held at press
// R2: init pulses bus init 150 ms, halted only
// R3: modifier halt stops processor, shows program counter
// R4: plain halt/step when halted steps once
// R5: continue releases halted processor, shows switch word
// R6: continue while running only redisplays switch word
// R7: start: load counter, init, run, show switch
// R8: boot activates bootstrap unit, halted only
// R9: modifier seven shows address plus display plus two
// R10: modifier six shows switch word plus display
// R11: modifier one enters maintenance, keys disabled
// R12: clear leaves maintenance through a processor halt
// R13: digits shift display left, never auto-cleared
// R14: operator enters digits before the function key
// R15: digit while switch shown keeps lamp lit
// R16: entered value is full address, no extension
// R17: program counter deposited at its bus address
// R18: examine and deposit only while halted
// R19: successive examine or deposit advance by two
// R20: general register range advances examine by one
// R21: load address takes display then zeroes it
// R22: keys debounced, acted on once per press
`timescale 1ns/1ps
`include "ckl_defines.svh"
module ckl_console #(
  parameter int INIT_CYC = `CKL_INIT_MS * `CKL_CLK_KHZ,
  parameter int DEB_CYC  = `CKL_DEB_MS * `CKL_CLK_KHZ,
  parameter int TMO_CYC  = `CKL_TMO_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [7:0]        digit_key,
  input  wire logic              modifier_key,
  input  wire logic              load_switch_word_key,
  input  wire logic              load_current_address_key,
  input  wire logic              show_current_address_key,
  input  wire logic              deposit_key,
  input  wire logic              examine_key,
  input  wire logic              zero_display_key,
  input  wire logic              halt_step_key,
  input  wire logic              continue_key,
  input  wire logic              start_key,
  input  wire logic              init_key,
  input  wire logic              boot_key,
  input  wire logic              halt_grant,
  input  wire logic              step_done,
  input  wire logic              bus_ack,
  input  wire logic              bus_fault,
  input  wire ckl_pkg::ckl_word_t bus_rdata,
  output logic                   halt_req,
  output logic                   step_req,
  output logic                   bus_init,
  output logic                   boot_enable,
  output logic                   bus_req,
  output logic                   bus_write,
  output ckl_pkg::ckl_addr_t     bus_addr,
  output ckl_pkg::ckl_word_t     bus_wdata,
  output ckl_pkg::ckl_addr_t     display,
  output ckl_pkg::ckl_word_t     switch_word,
  output logic                   switch_word_shown_lamp,
  output logic                   maint_lamp,
  output logic                   bus_error_lamp
);
  import ckl_pkg::*;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  localparam int TW = $clog2(INIT_CYC + 1);

  if (TMO_CYC < 1 || INIT_CYC <= TMO_CYC || DEB_CYC < 2) begin : g_bad
    $error("ckl_console: timing parameters out of range");
  end

  function automatic logic [2:0] digit_of(input logic [7:0] p);
    logic [2:0] d;
    d = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (p[k]) begin
        d = 3'(k);
      end
    end
    return d;
  endfunction

  function automatic logic is_gpr(input ckl_addr_t a);
    return (a >= `CKL_GPR_LO) && (a <= `CKL_GPR_HI);
  endfunction

  logic [`CKL_NKEYS-1:0] raw;
  logic [`CKL_NKEYS-1:0] held;
  logic [`CKL_NKEYS-1:0] press;

  ckl_state_e state_reg;
  ckl_op_e    op_reg;
  logic [TW-1:0] tmr_reg;
  ckl_addr_t  display_reg;
  ckl_addr_t  cur_addr_reg;
  ckl_addr_t  bus_addr_reg;
  ckl_word_t  bus_wdata_reg;
  ckl_word_t  switch_reg;
  logic       seq_reg;
  logic       halted_reg;
  logic       halt_req_reg;
  logic       step_req_reg;
  logic       bus_req_reg;
  logic       bus_write_reg;
  logic       maint_reg;
  logic       run_after_reg;
  logic       boot_reg;
  logic       sr_lamp_reg;
  logic       err_reg;

  assign raw = {modifier_key, boot_key, init_key, start_key,
                continue_key, halt_step_key, show_current_address_key,
                zero_display_key, examine_key, deposit_key,
                load_current_address_key, load_switch_word_key,
                digit_key};

  ckl_keydeb #(
    .W      (`CKL_NKEYS),
    .STABLE (DEB_CYC)
  ) u_deb (
    .clk   (clk),
    .rst   (rst),
    .raw   (raw),
    .held  (held),
    .press (press)
  );

  // commands decode on a press edge with the modifier level already held
  logic mod;
  logic idle;
  logic norm;
  logic [2:0] dsel;
  assign mod  = held[`CKL_K_MOD]; // R1
  assign idle = (state_reg == S_IDLE);
  assign norm = idle && !maint_reg; // R11
  assign dsel = digit_of(press[7:0]);

  logic c_digit, c_add7, c_add6, c_maint, c_lsr, c_lad, c_disad;
  logic c_clr, c_examine_key, c_dep, c_halt, c_step, c_cont, c_start;
  logic c_init, c_boot, c_mexit;
  assign c_digit = norm && !mod && (|press[7:0]);
  assign c_add7  = norm && mod && press[`CKL_D_ADD7];
  assign c_add6  = norm && mod && press[`CKL_D_ADD6];
  assign c_maint = norm && mod && press[`CKL_D_MAINT]; // R11
  assign c_lsr   = norm && press[`CKL_K_LSR];
  assign c_lad   = norm && press[`CKL_K_LAD];
  assign c_disad = norm && press[`CKL_K_DISAD];
  assign c_clr   = norm && press[`CKL_K_CLR];
  assign c_examine_key  = norm && press[`CKL_K_EXAMINE_KEY] && halted_reg; // R18
  assign c_dep   = norm && press[`CKL_K_DEP] && halted_reg; // R18
  assign c_halt  = norm && mod && press[`CKL_K_HS] && !halted_reg; // R3
  assign c_step  = norm && !mod && press[`CKL_K_HS] && halted_reg; // R4
  assign c_cont  = norm && mod && press[`CKL_K_CONT];
  assign c_start = norm && mod && press[`CKL_K_START] && halted_reg; // R7
  assign c_init  = norm && mod && press[`CKL_K_INIT] && halted_reg; // R2
  assign c_boot  = norm && mod && press[`CKL_K_BOOT] && halted_reg; // R8
  assign c_mexit = idle && maint_reg && press[`CKL_K_CLR]; // R12

  // successive accesses step by two, or by one for examines over the general registers
  ckl_addr_t addr_inc;
  ckl_addr_t addr_next;
  assign addr_inc  = (c_examine_key && is_gpr(cur_addr_reg)) ?
                     `CKL_STEP_GPR : `CKL_STEP_WIDE; // R20
  assign addr_next = seq_reg ? cur_addr_reg + addr_inc : cur_addr_reg; // R19

  logic tmo;
  logic init_done;
  logic wait_done;
  assign tmo       = (tmr_reg == TW'(TMO_CYC - 1));
  assign init_done = (state_reg == S_INIT) && (tmr_reg == TW'(INIT_CYC - 1));
  assign wait_done = (state_reg == S_HALT) ? halt_grant : step_done;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      op_reg <= OP_PC;
      tmr_reg <= '0;
      bus_req_reg <= 1'b0;
      bus_write_reg <= 1'b0;
      bus_addr_reg <= `CKL_ZERO;
      bus_wdata_reg <= '0;
      step_req_reg <= 1'b0;
    end else begin
      step_req_reg <= 1'b0;
      tmr_reg <= tmr_reg + TW'(1);
      case (state_reg)
        S_IDLE: begin
          tmr_reg <= '0;
          if (c_halt || (c_mexit && !halted_reg)) begin
            state_reg <= S_HALT; // R12
          end else if (c_step) begin
            step_req_reg <= 1'b1; // R4
            state_reg <= S_STEP;
          end else if (c_examine_key || c_dep) begin
            bus_req_reg <= 1'b1;
            bus_write_reg <= c_dep;
            bus_addr_reg <= addr_next; // R19
            bus_wdata_reg <= display_reg[15:0];
            op_reg <= c_dep ? OP_DEP : OP_EXAMINE_KEY;
            state_reg <= S_BUS;
          end else if (c_start) begin
            // counter is loaded first; init follows only an acknowledge of the write
            bus_req_reg <= 1'b1;
            bus_write_reg <= 1'b1;
            bus_addr_reg <= `CKL_PC_ADDR; // R17
            bus_wdata_reg <= cur_addr_reg[15:0]; // R7
            op_reg <= OP_START;
            state_reg <= S_BUS;
          end else if (c_init || c_boot) begin
            state_reg <= S_INIT; // R2
          end
        end
        S_HALT, S_STEP: begin
          if (wait_done) begin
            bus_req_reg <= 1'b1; // R3
            bus_write_reg <= 1'b0;
            bus_addr_reg <= `CKL_PC_ADDR;
            op_reg <= OP_PC;
            tmr_reg <= '0;
            state_reg <= S_BUS;
          end else if (tmo) begin
            state_reg <= S_IDLE;
          end
        end
        S_BUS: begin
          if (bus_ack || bus_fault || tmo) begin
            bus_req_reg <= 1'b0;
            tmr_reg <= '0;
            if (op_reg == OP_START && bus_ack) begin
              state_reg <= S_INIT; // R7
            end else begin
              state_reg <= S_IDLE;
            end
          end
        end
        S_INIT: begin
          if (init_done) begin
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // halt request stays up for as long as the processor is to stay halted
  always_ff @(posedge clk) begin
    if (rst) begin
      halt_req_reg <= 1'b0;
      halted_reg <= 1'b0;
    end else begin
      if (c_halt || (c_mexit && !halted_reg)) begin
        halt_req_reg <= 1'b1; // R3
      end else if (state_reg == S_HALT && halt_grant) begin
        halted_reg <= 1'b1;
      end else if (state_reg == S_HALT && tmo) begin
        halt_req_reg <= 1'b0;
      end else if (c_cont && halted_reg) begin
        halt_req_reg <= 1'b0; // R5
        halted_reg <= 1'b0;
      end else if (init_done && run_after_reg) begin
        halt_req_reg <= 1'b0; // R7
        halted_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      run_after_reg <= 1'b0;
      boot_reg <= 1'b0;
    end else if (c_start || c_boot) begin
      run_after_reg <= 1'b1;
      boot_reg <= c_boot; // R8
    end else if (c_init) begin
      run_after_reg <= 1'b0;
      boot_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      maint_reg <= 1'b0;
    end else if (c_maint) begin
      maint_reg <= 1'b1; // R11
    end else if (c_mexit && halted_reg) begin
      maint_reg <= 1'b0; // R12
    end else if (state_reg == S_HALT && halt_grant) begin
      maint_reg <= 1'b0; // R12
    end
  end

  // display is never cleared behind the operator's back
  always_ff @(posedge clk) begin
    if (rst) begin
      display_reg <= `CKL_ZERO;
    end else if (c_digit) begin
      display_reg <= {display_reg[14:0], dsel}; // R13
    end else if (c_add7) begin
      display_reg <= cur_addr_reg + display_reg + `CKL_STEP_WIDE; // R9
    end else if (c_add6) begin
      display_reg <= {`CKL_HI_ZERO, switch_reg} + display_reg; // R10
    end else if (c_lad || c_clr) begin
      display_reg <= `CKL_ZERO; // R21
    end else if (c_disad) begin
      display_reg <= cur_addr_reg;
    end else if (c_cont || (init_done && run_after_reg)) begin
      display_reg <= {`CKL_HI_ZERO, switch_reg}; // R5
    end else if (state_reg == S_BUS && bus_ack && !bus_write_reg) begin
      display_reg <= {`CKL_HI_ZERO, bus_rdata}; // R3
    end
  end

  // digits leave the lamp alone, so it may lie about the display
  always_ff @(posedge clk) begin
    if (rst) begin
      sr_lamp_reg <= 1'b0;
    end else if (c_cont || (init_done && run_after_reg)) begin
      sr_lamp_reg <= 1'b1; // R6
    end else if (c_add7 || c_add6 || c_lad || c_clr || c_disad ||
                 (state_reg == S_BUS && bus_ack && !bus_write_reg)) begin
      sr_lamp_reg <= 1'b0; // R15
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur_addr_reg <= `CKL_ZERO;
      seq_reg <= 1'b0;
    end else if (c_lad) begin
      cur_addr_reg <= display_reg; // R16
      seq_reg <= 1'b0;
    end else if (c_disad) begin
      seq_reg <= 1'b0;
    end else if (c_examine_key || c_dep) begin
      cur_addr_reg <= addr_next; // R19
      seq_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      switch_reg <= '0;
    end else if (c_lsr) begin
      switch_reg <= display_reg[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      err_reg <= 1'b0;
    end else if (((state_reg == S_HALT || state_reg == S_STEP) &&
                  !wait_done && tmo) ||
                 (state_reg == S_BUS && !bus_ack && (bus_fault || tmo))) begin
      err_reg <= 1'b1;
    end else if (c_clr) begin
      err_reg <= 1'b0;
    end
  end

  assign halt_req    = halt_req_reg;
  assign step_req    = step_req_reg;
  assign bus_init    = (state_reg == S_INIT); // R2
  assign boot_enable = (state_reg == S_INIT) && boot_reg; // R8
  assign bus_req     = bus_req_reg;
  assign bus_write   = bus_write_reg;
  assign bus_addr    = bus_addr_reg;
  assign bus_wdata   = bus_wdata_reg;
  assign display     = display_reg;
  assign switch_word = switch_reg;
  assign switch_word_shown_lamp = sr_lamp_reg;
  assign maint_lamp     = maint_reg;
  assign bus_error_lamp = err_reg;

  // helper count of bus init length
  logic [TW-1:0] hp_init_reg;
  always_ff @(posedge clk) begin
    if (rst || !bus_init) begin
      hp_init_reg <= '0;
    end else begin
      hp_init_reg <= hp_init_reg + TW'(1);
    end
  end

  sequence s_halt_cmd;
    c_halt;
  endsequence
  sequence s_pc_read;
    bus_req_reg && !bus_write_reg && bus_addr_reg == `CKL_PC_ADDR;
  endsequence

  a_halt_req: assert property (s_halt_cmd |=> halt_req_reg // R3
      && state_reg == S_HALT)
    else $error("halt command did not raise halt request");
  a_halt_pc: assert property (state_reg == S_HALT && halt_grant // R3
      |=> s_pc_read)
    else $error("counter not read after halt grant");
  a_step_once: assert property (c_step |=> step_req_reg // R4
      ##1 !step_req_reg)
    else $error("step request not a single pulse");
  a_init_len: assert property ($fell(bus_init) // R2
      |-> hp_init_reg == TW'(INIT_CYC))
    else $error("bus init length wrong");
  a_init_halt: assert property ($rose(bus_init) |-> halted_reg) // R2
    else $error("bus init while running");
  a_start_pc: assert property (c_start |=> bus_write_reg // R7
      && bus_addr_reg == `CKL_PC_ADDR
      && bus_wdata_reg == $past(cur_addr_reg[15:0]))
    else $error("start did not load the counter");
  a_cont_show: assert property (c_cont |=> sr_lamp_reg // R5
      && display_reg == {`CKL_HI_ZERO, $past(switch_reg)})
    else $error("continue did not show switch word");
  a_cont_run: assert property (c_cont && !halted_reg // R6
      |=> !halted_reg && $stable(halt_req_reg))
    else $error("continue disturbed running processor");
  a_digit_shift: assert property (c_digit |=> display_reg == // R13
      {$past(display_reg[14:0]), $past(dsel)})
    else $error("digit entry wrong");
  a_lamp_keep: assert property (c_digit |=> $stable(sr_lamp_reg)) // R15
    else $error("digit changed switch lamp");
  a_sum_seven: assert property (c_add7 |=> display_reg == // R9
      $past(cur_addr_reg) + $past(display_reg) + `CKL_STEP_WIDE)
    else $error("offset sum wrong");
  a_bus_halted: assert property (bus_req_reg |-> halted_reg) // R18
    else $error("bus access while running");
  a_maint_mute: assert property (maint_reg && idle && (|press[7:0]) // R11
      |=> $stable(display_reg))
    else $error("digit acted in maintenance mode");
endmodule

// ===== testbench/ckl_proc_model.sv
// processor and bus model facing the console keypad logic
// assumes the console clock; grants a halt one cycle after the request
`timescale 1ns/1ps
module ckl_proc_model #(
  parameter int DLY = 2
) (
  input  wire logic        clk,
  input  wire logic        halt_req,
  input  wire logic        step_req,
  input  wire logic        bus_req,
  input  wire logic        bus_write,
  input  wire logic [17:0] bus_addr,
  input  wire logic [15:0] bus_wdata,
  output logic             halt_grant,
  output logic             step_done,
  output logic             bus_ack,
  output logic             bus_fault,
  output logic      [15:0] bus_rdata,
  output logic      [17:0] last_addr,
  output logic      [15:0] pc
);
  logic [15:0] mem [0:255];
  int          wt;
  initial begin
    halt_grant = 1'b0;
    step_done  = 1'b0;
    bus_ack    = 1'b0;
    bus_fault  = 1'b0;
    bus_rdata  = 16'h5a5a;
    last_addr  = 18'h00000;
    pc         = 16'o1006;
    wt         = 0;
    foreach (mem[i]) mem[i] = 16'(i);
  end
  always @(posedge clk) begin
    halt_grant <= halt_req;
    step_done  <= step_req;
    if (step_req)
      pc <= pc + 16'h0002;
    bus_ack <= 1'b0;
    bus_fault <= 1'b0;
    // read data is only valid with the ack, so it churns otherwise
    bus_rdata <= ~bus_rdata;
    if (bus_req && !bus_ack && !bus_fault) begin
      wt <= wt + 1;
      if (wt == DLY) begin
        wt        <= 0;
        // one hole in the address map answers with a fault instead
        bus_ack   <= (bus_addr != 18'o760000);
        bus_fault <= (bus_addr == 18'o760000);
        last_addr <= bus_addr;
        if (bus_addr == 18'o777707) begin
          if (bus_write)
            pc <= bus_wdata;
          else
            bus_rdata <= pc;
        end else if (bus_write)
          mem[bus_addr[8:1]] <= bus_wdata;
        else
          bus_rdata <= mem[bus_addr[8:1]];
      end
    end
  end
endmodule

// ===== testbench/tb_top.sv
// self-checking bench for the console keypad command logic
// assumes short debounce, init and timeout counts set at the instance
`timescale 1ns/1ps
`include "ckl_defines.svh"
module tb_top;
  import ckl_pkg::*;
  logic        clk;
  logic        rst;
  logic [19:0] k;
  logic        hg, sd, ack, flt, hr, sr, bi, be, brq, bw, swl, ml, el;
  ckl_word_t   rd, wd, sw, pc;
  ckl_addr_t   ba, disp, la;
  int          error_cnt, n_compared, n_init, n_boot, cycles;
  localparam int HS = `CKL_K_HS;
  localparam int CL = `CKL_K_CLR;
  localparam int LA = `CKL_K_LAD;
  localparam int EX = `CKL_K_EXAMINE_KEY;
  localparam int CO = `CKL_K_CONT;

  ckl_console #(.INIT_CYC(40), .DEB_CYC(4), .TMO_CYC(10)) uut (
    .clk(clk), .rst(rst), .digit_key(k[7:0]), .modifier_key(k[19]),
    .load_switch_word_key(k[8]), .load_current_address_key(k[9]),
    .show_current_address_key(k[13]), .deposit_key(k[10]),
    .examine_key(k[11]), .zero_display_key(k[12]),
    .halt_step_key(k[14]), .continue_key(k[15]), .start_key(k[16]),
    .init_key(k[17]), .boot_key(k[18]), .halt_grant(hg),
    .step_done(sd), .bus_ack(ack), .bus_fault(flt), .bus_rdata(rd),
    .halt_req(hr), .step_req(sr), .bus_init(bi), .boot_enable(be),
    .bus_req(brq), .bus_write(bw), .bus_addr(ba), .bus_wdata(wd),
    .display(disp), .switch_word(sw), .switch_word_shown_lamp(swl),
    .maint_lamp(ml), .bus_error_lamp(el));

  ckl_proc_model #(.DLY(2)) model (
    .clk(clk), .halt_req(hr), .step_req(sr), .bus_req(brq),
    .bus_write(bw), .bus_addr(ba), .bus_wdata(wd), .halt_grant(hg),
    .step_done(sd), .bus_ack(ack), .bus_fault(flt), .bus_rdata(rd),
    .last_addr(la), .pc(pc));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(negedge clk) begin
    if (bi)
      n_init++;
    if (be)
      n_boot++;
  end

  // a hang ends the run here rather than never
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [17:0] got, logic [17:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %o seen %o", nm, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask

  // m 1: modifier held first; m 2: modifier only after the key
  task automatic key(int i, int m = 0);
    if (m == 1) begin
      k[19] = 1'b1;
      cyc(10);
    end
    k[i] = 1'b1;
    cyc(2);
    if (m == 2)
      k[19] = 1'b1;
    cyc(10);
    k[i]  = 1'b0;
    k[19] = 1'b0;
    cyc(14);
  endtask

  // operand digits go in before the function key
  task automatic num(logic [17:0] v);
    for (int j = 5; j >= 0; j--)
      key(int'(v[3*j+:3]));
  endtask

  task automatic t_digits();
    key(CL);
    num(18'o123456);
    key(7);
    chk("display", disp, 18'o234567);
    k[3] = 1'b1;
    cyc(40);
    k[3] = 1'b0;
    cyc(14);
    chk("display", disp, 18'o345673);
    $display("test digits done");
  endtask

  task automatic t_halt();
    key(HS, 2);
    chk("halt_req", {17'h0, hr}, 18'h0);
    key(HS, 1);
    chk("halt_req", {17'h0, hr}, 18'h1);
    chk("display", disp, 18'o001006);
    key(HS);
    chk("display", disp, 18'o001010);
    key(CL);
    num(18'o777707);
    key(LA);
    num(18'o001000);
    key(`CKL_K_DEP);
    key(HS);
    chk("display", disp, 18'o001002);
    $display("test halt done");
  endtask

  task automatic t_bus();
    key(CL);
    num(18'o001000);
    key(LA);
    chk("display", disp, 18'o0);
    num(18'o012737);
    key(`CKL_K_DEP);
    key(CL);
    num(18'o177777);
    key(`CKL_K_DEP);
    chk("address", la, 18'o001002);
    key(CL);
    num(18'o001000);
    key(LA);
    key(EX);
    chk("display", disp, 18'o012737);
    key(EX);
    chk("display", disp, 18'o177777);
    key(7, 1);
    chk("display", disp, 18'o201003);
    key(CL);
    num(18'o125252);
    key(`CKL_K_LSR);
    chk("switch", {2'h0, sw}, 18'o125252);
    key(CL);
    num(18'o000010);
    key(6, 1);
    chk("display", disp, 18'o125262);
    key(CL);
    num(18'o777710);
    key(LA);
    key(EX);
    key(EX);
    chk("address", la, 18'o777711);
    key(CL);
    num(18'o177560);
    key(LA);
    key(EX);
    chk("address", la, 18'o177560);
    key(`CKL_K_DISAD);
    chk("display", disp, 18'o177560);
    key(CL);
    num(18'o760000);
    key(LA);
    key(EX);
    chk("error lamp", {17'h0, el}, 18'h1);
    key(CL);
    chk("error lamp", {17'h0, el}, 18'h0);
    $display("test bus done");
  endtask

  task automatic t_init();
    n_init = 0;
    key(`CKL_K_INIT, 1);
    cyc(60);
    chk("init cycles", 18'(n_init), 18'd40);
    n_boot = 0;
    key(`CKL_K_BOOT, 1);
    cyc(60);
    chk("boot cycles", 18'(n_boot), 18'd40);
    n_init = 0;
    key(`CKL_K_INIT, 1);
    cyc(60);
    chk("init cycles", 18'(n_init), 18'd0);
    key(CL);
    key(EX);
    chk("display", disp, 18'o0);
    $display("test init done");
  endtask

  task automatic t_run();
    key(CO, 1);
    chk("lamp", {17'h0, swl}, 18'h1);
    key(5);
    chk("display", disp, 18'o252525);
    chk("lamp", {17'h0, swl}, 18'h1);
    key(CO, 1);
    chk("display", disp, 18'o125252);
    key(HS, 1);
    key(CO, 1);
    chk("halt_req", {17'h0, hr}, 18'h0);
    chk("display", disp, 18'o125252);
    key(HS, 1);
    key(CL);
    num(18'o001000);
    key(LA);
    n_init = 0;
    key(`CKL_K_START, 1);
    cyc(60);
    chk("pc", {2'h0, pc}, 18'o001000);
    chk("init cycles", 18'(n_init), 18'd40);
    chk("halt_req", {17'h0, hr}, 18'h0);
    chk("display", disp, 18'o125252);
    key(1, 1);
    chk("maint", {17'h0, ml}, 18'h1);
    key(4);
    chk("display", disp, 18'o125252);
    key(CL);
    chk("maint", {17'h0, ml}, 18'h0);
    chk("halt_req", {17'h0, hr}, 18'h1);
    $display("test run done");
  endtask

  initial begin
    rst        = 1'b1;
    k          = 20'h00000;
    error_cnt  = 0;
    n_compared = 0;
    n_init     = 0;
    n_boot     = 0;
    cycles     = 0;
    cyc(8);
    rst = 1'b0;
    cyc(2);
    t_digits();
    t_halt();
    t_bus();
    t_init();
    t_run();
    summarize();
  end
endmodule
